/* include/flash_fault_pkg.sv */
/*
 * Package for the flash driver fault/drive-doubling register bank: register
 * addresses, field positions, reset values, unlock key and carrier structs.
 * Assumes the surrounding I2C slave decodes frames into single-byte accesses.
 */
package flash_fault_pkg;

    localparam int unsigned ADDR_W            = 8;
    localparam int unsigned DATA_W            = 8;

    localparam logic [7:0] ADDR_FAULT_STATUS  = 8'h05;
    localparam logic [7:0] ADDR_DRIVE_DOUBLING = 8'h0d;
    localparam logic [7:0] ADDR_UNLOCK_KEY    = 8'h0f;

    localparam int unsigned BIT_RESERVED      = 0;
    localparam int unsigned BIT_COIL_LIMIT    = 1;
    localparam int unsigned BIT_IND_FAULT     = 2;
    localparam int unsigned BIT_LED_COUNT     = 3;
    localparam int unsigned BIT_FLASH_EXPIRY  = 4;
    localparam int unsigned BIT_THERMAL       = 5;
    localparam int unsigned BIT_LED_SHORT     = 6;
    localparam int unsigned BIT_OVERVOLTAGE   = 7;
    localparam int unsigned BIT_DOUBLE_DRIVE  = 0;

    localparam logic       LED_COUNT_RESET    = 1'b1;
    localparam logic       DOUBLE_RESET       = 1'b0;
    localparam logic [7:0] UNLOCK_KEY_RESET   = 8'h00;
    localparam logic [7:0] UNLOCK_VALUE       = 8'h55;
    localparam logic       RESERVED_READ      = 1'b0;

    // analog detector levels, one per fault source
    typedef struct packed {
        logic overvoltage;
        logic led_short;
        logic thermal;
        logic flash_expiry;
        logic ind_fault;
        logic coil_limit;
    } fault_in_t;

    // one decoded register access from the serial slave
    typedef struct packed {
        logic              wr;
        logic              rd;
        logic              cmd_end;
        logic [ADDR_W-1:0] addr;
        logic [DATA_W-1:0] wdata;
    } reg_req_t;

endpackage : flash_fault_pkg

/* logic/flash_fault_boost_regs.sv */
/*
 * Fault status, drive-doubling and unlock key registers of a flash LED driver.
 * Assumes an I2C slave front end that presents each byte access as a one-cycle
 * strobe and pulses cmd_end at the stop/restart closing each write command.
 */
`timescale 1ns/1ns

module flash_fault_boost_regs
    import flash_fault_pkg::*;
(
    // clock and reset
    input  wire logic                    ref_clk,
    input  wire logic                    rst_n,
    // register access from the serial slave
    input  wire flash_fault_pkg::reg_req_t req,
    output logic [flash_fault_pkg::DATA_W-1:0] rdata,
    // fault detector levels
    input  wire flash_fault_pkg::fault_in_t  faults,
    // controls to the analog core
    output logic                         double_drive,
    output logic                         led_count
);
    import flash_fault_pkg::*;

    // register selects
    logic                    sel_fault;
    logic                    sel_double;
    logic                    sel_key;
    logic                    key_write;
    logic                    key_match;
    logic                    dd_write;
    logic                    dd_load;
    logic                    count_write;
    // unlock tracking
    logic                    unlocked;
    logic                    key_frame;
    // read path
    logic       [DATA_W-1:0] fault_flags;
    logic       [DATA_W-1:0] fault_view;
    logic       [DATA_W-1:0] double_view;
    logic       [DATA_W-1:0] next_rdata;

    assign sel_fault   = (req.addr == ADDR_FAULT_STATUS);
    assign sel_double  = (req.addr == ADDR_DRIVE_DOUBLING);
    assign sel_key     = (req.addr == ADDR_UNLOCK_KEY);
    assign key_write   = req.wr && sel_key;
    assign key_match   = (req.wdata == UNLOCK_VALUE);
    assign dd_write    = req.wr && sel_double;
    assign dd_load     = dd_write && unlocked;
    assign count_write = req.wr && sel_fault;

    // fault flags follow the detectors, read-only, one cycle behind

    // reserved position reads a fixed level
    fault_flag_cell flag_reserved_inst (
        .ref_clk (ref_clk),
        .rst_n   (rst_n),
        .level   (RESERVED_READ),
        .flag    (fault_flags[BIT_RESERVED])
    );

    // coil current above its limit
    fault_flag_cell flag_coil_inst (
        .ref_clk (ref_clk),
        .rst_n   (rst_n),
        .level   (faults.coil_limit),
        .flag    (fault_flags[BIT_COIL_LIMIT])
    );

    // indicator output fault
    fault_flag_cell flag_ind_inst (
        .ref_clk (ref_clk),
        .rst_n   (rst_n),
        .level   (faults.ind_fault),
        .flag    (fault_flags[BIT_IND_FAULT])
    );

    // flash duration limit hit
    fault_flag_cell flag_expiry_inst (
        .ref_clk (ref_clk),
        .rst_n   (rst_n),
        .level   (faults.flash_expiry),
        .flag    (fault_flags[BIT_FLASH_EXPIRY])
    );

    // junction too hot
    fault_flag_cell flag_thermal_inst (
        .ref_clk (ref_clk),
        .rst_n   (rst_n),
        .level   (faults.thermal),
        .flag    (fault_flags[BIT_THERMAL])
    );

    // shorted flash led
    fault_flag_cell flag_short_inst (
        .ref_clk (ref_clk),
        .rst_n   (rst_n),
        .level   (faults.led_short),
        .flag    (fault_flags[BIT_LED_SHORT])
    );

    // boost output overvoltage
    fault_flag_cell flag_ovp_inst (
        .ref_clk (ref_clk),
        .rst_n   (rst_n),
        .level   (faults.overvoltage),
        .flag    (fault_flags[BIT_OVERVOLTAGE])
    );

    // led count position is filled from its own register
    assign fault_flags[BIT_LED_COUNT] = 1'b0;

    // led count flag, host writable
    guarded_bit_cell #(
        .RESET_VALUE (LED_COUNT_RESET)
    ) count_bit_inst (
        .ref_clk (ref_clk),
        .rst_n   (rst_n),
        .load    (count_write),
        .value   (req.wdata[BIT_LED_COUNT]),
        .bit_q   (led_count)
    );

    // drive-doubling bit, loads only while unlocked
    guarded_bit_cell #(
        .RESET_VALUE (DOUBLE_RESET)
    ) double_bit_inst (
        .ref_clk (ref_clk),
        .rst_n   (rst_n),
        .load    (dd_load),
        .value   (req.wdata[BIT_DOUBLE_DRIVE]),
        .bit_q   (double_drive)
    );

    // unlock armed by a matching key; survives the end of the key's own
    // command, spent by a doubling write or the end of the next command
    always_ff @(posedge ref_clk) begin
        if (!rst_n) begin
            unlocked <= 1'b0;
        end else if (key_write) begin
            unlocked <= key_match;
        end else if (dd_write) begin
            unlocked <= 1'b0;
        end else if (req.cmd_end && !key_frame) begin
            unlocked <= 1'b0;
        end
    end

    // high while the command that carried the key is still open
    always_ff @(posedge ref_clk) begin
        if (!rst_n) begin
            key_frame <= 1'b0;
        end else if (key_write) begin
            key_frame <= key_match && !req.cmd_end;
        end else if (req.cmd_end) begin
            key_frame <= 1'b0;
        end
    end

    // read views of the two readable registers
    assign fault_view  = fault_flags | (DATA_W'(led_count) << BIT_LED_COUNT);
    assign double_view = DATA_W'(double_drive);

    // read select; key register is write-only and reads zero
    always_comb begin
        next_rdata = '0;
        case (req.addr)
            ADDR_FAULT_STATUS: begin
                next_rdata = fault_view;
            end
            ADDR_DRIVE_DOUBLING: begin
                next_rdata = double_view;
            end
            default: begin
                next_rdata = '0;
            end
        endcase
    end

    // read data stands until the next read
    always_ff @(posedge ref_clk) begin
        if (!rst_n) begin
            rdata <= '0;
        end else if (req.rd) begin
            rdata <= next_rdata;
        end
    end

endmodule : flash_fault_boost_regs

// one live fault flag, cleared by reset
module fault_flag_cell (
    // clock and reset
    input  wire logic ref_clk,
    input  wire logic rst_n,
    // detector level in, flag out
    input  wire logic level,
    output logic      flag
);

    always_ff @(posedge ref_clk) begin
        if (!rst_n) begin
            flag <= 1'b0;
        end else begin
            flag <= level;
        end
    end

endmodule : fault_flag_cell

// one register bit with a load strobe
module guarded_bit_cell #(
    parameter logic RESET_VALUE = 1'b0
) (
    // clock and reset
    input  wire logic ref_clk,
    input  wire logic rst_n,
    // load strobe and value
    input  wire logic load,
    input  wire logic value,
    output logic      bit_q
);

    always_ff @(posedge ref_clk) begin
        if (!rst_n) begin
            bit_q <= RESET_VALUE;
        end else if (load) begin
            bit_q <= value;
        end
    end

endmodule : guarded_bit_cell

/* tb/bank_chk_properties.sv */
/* port checker for the fault and drive-doubling bank; assumes bind to every bank instance */
`timescale 1ns/1ns
module bank_chk
    import flash_fault_pkg::*;
(
    input wire logic                      ref_clk,
    input wire logic                      rst_n,
    input wire flash_fault_pkg::reg_req_t  req,
    input wire logic [7:0]                rdata,
    input wire flash_fault_pkg::fault_in_t faults,
    input wire logic                      double_drive,
    input wire logic                      led_count
);
    default clocking dc @(posedge ref_clk); endclocking
    default disable iff (!rst_n);
    logic       unl;
    logic       kf;
    logic [5:0] f1, f2;
    wire rd5 = req.rd && req.addr == 8'h05;
    wire wr5 = req.wr && req.addr == 8'h05;
    wire bw = req.wr && req.addr == 8'h0d;
    wire kw = req.wr && req.addr == 8'h0f && req.wdata == 8'h55;
    // key wins over cmd_end; the key's own command end keeps it, the next one or a doubling write relocks
    always_ff @(posedge ref_clk) unl <= rst_n && (req.wr && req.addr == 8'h0f ? kw : unl && !(req.cmd_end && !kf) && !bw);
    always_ff @(posedge ref_clk) kf <= rst_n && (req.wr && req.addr == 8'h0f ? kw && !req.cmd_end : kf && !req.cmd_end);
    always_ff @(posedge ref_clk) f1 <= faults;
    always_ff @(posedge ref_clk) f2 <= f1;
    sequence s_unlock; kw ##1 (!req.wr && !req.cmd_end) ##1 bw; endsequence
    coil_flag_a: assert property (rd5 |=> rdata[1] == f2[0]) else $error("coil flag");
    ind_flag_a: assert property (rd5 |=> rdata[2] == f2[1]) else $error("ind flag");
    upper_flags_a: assert property (rd5 |=> rdata[7:4] == f2[5:2]) else $error("upper flags");
    count_read_a: assert property (rd5 |=> rdata[3] == $past(led_count)) else $error("count read");
    reserved_bit_a: assert property (rd5 |=> !rdata[0]) else $error("reserved bit");
    count_write_a: assert property (wr5 |=> led_count == $past(req.wdata[3])) else $error("count write");
    locked_ignore_a: assert property (bw && !unl |=> $stable(double_drive)) else $error("locked write");
    unlock_take_a: assert property (s_unlock |=> double_drive == $past(req.wdata[0])) else $error("unlock");
    reset_val_a: assert property ($rose(rst_n) |-> !double_drive && led_count && rdata == 8'h00) else $error("reset");
endmodule : bank_chk
bind flash_fault_boost_regs bank_chk bank_chk_inst (.ref_clk(ref_clk), .rst_n(rst_n), .req(req), .rdata(rdata),
    .faults(faults), .double_drive(double_drive), .led_count(led_count));

/* tb/flash_fault_boost_regs_bench.sv */
/* self-checking bench for the bank; assumes the host model and the bound checker */
`timescale 1ns/1ns
module flash_fault_boost_regs_bench;
    import flash_fault_pkg::*;
    logic       ref_clk = 0;
    logic       rst_n = 0;
    fault_in_t  faults = '0;
    reg_req_t   req;
    logic [7:0] rdata;
    logic       double_drive, led_count;
    int         bad_count = 0, n_checks = 0;
    host_model host_model_inst (.ref_clk(ref_clk), .req(req));
    flash_fault_boost_regs flash_fault_boost_regs_inst (.ref_clk(ref_clk), .rst_n(rst_n), .req(req),
        .rdata(rdata), .faults(faults), .double_drive(double_drive), .led_count(led_count));
    initial forever #4 ref_clk = ~ref_clk;
    task chk(input string n, input logic [7:0] e, input logic [7:0] g);
        n_checks++;
        if (g !== e) begin
            bad_count++;
            $display("wrong value %s expected %h seen %h", n, e, g);
        end
    endtask : chk
    task test_done;
        $display("checks %0d mismatches %0d", n_checks, bad_count);
        if (bad_count == 0 && n_checks > 0) $display("bench passed");
        else $display("bench failed");
        $finish;
    endtask : test_done
    task rd(input logic [7:0] a, input logic [7:0] e);
        host_model_inst.xfer(3'b010, a, 8'h00);
        @(negedge ref_clk);
        chk("rdata", e, rdata);
    endtask : rd
    task chk_drive(input logic [7:0] e);
        @(negedge ref_clk);
        chk("drive", e, {7'h0, double_drive});
    endtask : chk_drive
    initial begin
        repeat (10) @(posedge ref_clk);
        rst_n <= 1;
        rd(8'h05, 8'h08);
        chk("drive", 8'h00, {7'h0, double_drive});
        for (int i = 0; i < 6; i++) begin
            faults <= 6'h01 << i;
            @(posedge ref_clk);
            rd(8'h05, ((i < 2 ? 8'h02 : 8'h04) << i) | 8'h08);
        end
        faults <= '0;
        host_model_inst.xfer(3'b100, 8'h05, 8'hf7);
        rd(8'h05, 8'h00);
        host_model_inst.xfer(3'b100, 8'h0d, 8'h01);
        host_model_inst.xfer(3'b100, 8'h0f, 8'h56);
        host_model_inst.xfer(3'b100, 8'h0d, 8'h01);
        host_model_inst.xfer(3'b100, 8'h0f, 8'h55);
        host_model_inst.xfer(3'b001, 8'h00, 8'h00);
        host_model_inst.xfer(3'b100, 8'h05, 8'h00);
        host_model_inst.xfer(3'b001, 8'h00, 8'h00);
        host_model_inst.xfer(3'b100, 8'h0d, 8'h01);
        chk_drive(8'h00);
        host_model_inst.boost(8'h01);
        chk_drive(8'h01);
        rd(8'h0d, 8'h01);
        host_model_inst.xfer(3'b100, 8'h0d, 8'h00);
        chk_drive(8'h01);
        host_model_inst.xfer(3'b100, 8'h0f, 8'h55);
        host_model_inst.xfer(3'b001, 8'h00, 8'h00);
        host_model_inst.xfer(3'b100, 8'h0d, 8'h00);
        chk_drive(8'h00);
        rd(8'h0f, 8'h00);
        test_done();
    end
    initial begin
        #100000;
        bad_count++;
        test_done();
    end
endmodule : flash_fault_boost_regs_bench

/* tb/host_model.sv */
/* host master model issuing single-byte accesses; assumes one shared clock */
`timescale 1ns/1ns
module host_model
    import flash_fault_pkg::*;
(
    input wire logic                     ref_clk,
    output flash_fault_pkg::reg_req_t     req
);
    initial req = '0;
    // released lines show inverted values
    task xfer(input logic [2:0] k, input logic [7:0] a, input logic [7:0] d);
        @(posedge ref_clk) req <= {k, a, d};
        @(posedge ref_clk) req <= {3'b000, ~a, ~d};
    endtask : xfer
    task boost(input logic [7:0] d);
        if (d[0]) xfer(3'b100, 8'h05, 8'h00);
        xfer(3'b100, 8'h0f, 8'h55);
        xfer(3'b100, 8'h0d, d);
        xfer(3'b001, 8'h00, 8'h00);
    endtask : boost
endmodule : host_model
